/* File: rtl/esic_irq_ctrl.v */
// eight source two level interrupt controller with apb register access
// --------------------
// Overview of operation
// [R1] vectors 03h to 2bh for six standard sources
// [R2] vectors 33h, 3bh for external pins 2, 3
// [R3] fixed polling order within one level
// [R4] global enable in top bit gates everything; the irq event status output is not gated by it
// [R5] per-source enable bits for six standard sources
// [R6] extra-control bits 2, 6 enable pins 2, 3
// [R7] priority register bits select high level
// [R8] extra-control bits 3, 7 raise pins 2, 3
// [R9] pins 2, 3 falling edge or low level
// [R10] pins 2, 3 edge flag set, cleared on service
// [R11] timer 0 overflow flag cleared on vectoring
// [R12] timer 1 overflow flag cleared on vectoring
// [R13] pins 0, 1 falling edge or low level
// [R14] pins 0, 1 edge flag set, cleared on service
// [R15] timer 2 flags request; software clears them
// [R16] high preempts low, never the reverse
// [R17] level mode does not latch requests
// --------------------
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "esic_defines.vh"

module esic_irq_ctrl #(
  parameter NSRC = 8                // number of sources
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  ext0_irq_pin,
  ext1_irq_pin,
  ext2_irq_pin,
  ext3_irq_pin,
  tmr0_overflow,
  tmr1_overflow,
  tmr2_overflow,
  tmr2_transition,
  serial_req,
  cpu_irq_req,
  cpu_irq_vector,
  cpu_irq_ack,
  cpu_irq_return,
  irq
);
  input  wire        pclk;            // core clock
  input  wire        presetn;         // async reset, active low
  input  wire        psel;            // apb select
  input  wire        penable;         // apb access phase
  input  wire        pwrite;          // apb direction
  input  wire [7:0]  paddr;           // apb byte address
  input  wire [31:0] pwdata;          // apb write data
  output reg  [31:0] prdata;          // apb read data
  output wire        pready;          // apb ready
  output wire        pslverr;         // apb error on unmapped address
  input  wire        ext0_irq_pin;    // external pin 0, active low
  input  wire        ext1_irq_pin;    // external pin 1, active low
  input  wire        ext2_irq_pin;    // external pin 2, active low
  input  wire        ext3_irq_pin;    // external pin 3, active low
  input  wire        tmr0_overflow;   // timer 0 overflow pulse
  input  wire        tmr1_overflow;   // timer 1 overflow pulse
  input  wire        tmr2_overflow;   // timer 2 overflow pulse
  input  wire        tmr2_transition; // timer 2 external transition pulse
  input  wire        serial_req;      // serial port request level
  output reg         cpu_irq_req;     // request pending towards the core
  output reg  [7:0]  cpu_irq_vector;  // vector of pending request
  input  wire        cpu_irq_ack;     // core vectors now (one cycle)
  input  wire        cpu_irq_return;  // core returns from a routine
  output wire        irq;             // unmasked event status level

  // --------------------
  // registers
  // --------------------
  reg  [7:0]      timer_ext_irq_ctrl; // timer flags, pin 0/1 control
  reg  [7:0]      irq_enable_reg;     // enables
  reg  [7:0]      irq_priority_reg;   // priority bits
  reg  [7:0]      ext23_irq_ctrl;     // pin 2/3 control
  reg             tmr2_overflow_flag; // timer 2 overflow flag
  reg             tmr2_transition_flag; // timer 2 external flag
  reg  [NSRC-1:0] ev_status;          // sticky event bits
  reg  [NSRC-1:0] ev_mask;            // event mask
  reg  [3:0]      pin_last;           // previous pin samples
  reg             in_hi;              // a high level routine is running
  reg             in_lo;              // a low level routine is running
  reg  [NSRC-1:0] next_ev_status;     // next sticky value
  reg  [2:0]      cur_idx;            // source of the posted request
  reg             cur_hi;             // posted request is high level

  // --------------------
  // apb decode; zero wait states, so pready is tied high
  // --------------------
  wire apb_acc  = psel & penable;
  wire apb_wr   = apb_acc & pwrite;
  wire apb_rd   = apb_acc & ~pwrite;
  reg  addr_hit;                      // address maps a register

  always @* begin
    if (paddr == `ESIC_ADDR_TCTRL)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_IEN)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_IPRI)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_XCTRL)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_T2FLAGS)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_ACK)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_EVSTAT)
      addr_hit = 1'b1;
    else if (paddr == `ESIC_ADDR_EVMASK)
      addr_hit = 1'b1;
    else
      addr_hit = 1'b0;
  end

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~addr_hit;

  // --------------------
  // falling edge detectors for the four pins
  // --------------------
  wire [3:0] pins = {ext3_irq_pin, ext2_irq_pin, ext1_irq_pin, ext0_irq_pin};
  wire [3:0] fall = pin_last & ~pins;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pin_last <= 4'hf;               // idle high so reset is no edge
    else
      pin_last <= pins;
  end

  // --------------------
  // per-source request, enable and level vectors
  // --------------------
  wire it0 = timer_ext_irq_ctrl[`ESIC_TC_IT0];
  wire it1 = timer_ext_irq_ctrl[`ESIC_TC_IT1];
  wire it2 = ext23_irq_ctrl[`ESIC_XC_IT2];
  wire it3 = ext23_irq_ctrl[`ESIC_XC_IT3];

  // level mode looks at the pin only, the latched flag is ignored
  wire r_ext0 = it0 ? timer_ext_irq_ctrl[`ESIC_TC_IE0] : ~ext0_irq_pin;   // [R13] [R17]
  wire r_ext1 = it1 ? timer_ext_irq_ctrl[`ESIC_TC_IE1] : ~ext1_irq_pin;   // [R13] [R17]
  wire r_ext2 = it2 ? ext23_irq_ctrl[`ESIC_XC_IE2] : ~ext2_irq_pin;       // [R9] [R17]
  wire r_ext3 = it3 ? ext23_irq_ctrl[`ESIC_XC_IE3] : ~ext3_irq_pin;       // [R9] [R17]
  wire r_tmr2 = tmr2_overflow_flag | tmr2_transition_flag;                // [R15]

  wire [NSRC-1:0] src_req = {r_ext3, r_ext2, r_tmr2, serial_req,
                             timer_ext_irq_ctrl[`ESIC_TC_TF1], r_ext1,
                             timer_ext_irq_ctrl[`ESIC_TC_TF0], r_ext0};
  wire [NSRC-1:0] src_en  = {ext23_irq_ctrl[`ESIC_XC_EX3],
                             ext23_irq_ctrl[`ESIC_XC_EX2],
                             irq_enable_reg[5:0]};                         // [R5] [R6]
  wire [NSRC-1:0] src_hi  = {ext23_irq_ctrl[`ESIC_XC_PX3],
                             ext23_irq_ctrl[`ESIC_XC_PX2],
                             irq_priority_reg[5:0]};                       // [R7] [R8]

  wire            global_irq_enable = irq_enable_reg[`ESIC_GLOBAL_BIT];
  wire [NSRC-1:0] live   = src_req & src_en & {NSRC{global_irq_enable}}; // [R4]
  wire [NSRC-1:0] req_hi = live & src_hi;
  wire [NSRC-1:0] req_lo = live & ~src_hi;

  // --------------------
  // one picker per level, shared fixed-order module
  // --------------------
  wire       hi_any;
  wire       lo_any;
  wire [2:0] hi_idx;
  wire [2:0] lo_idx;
  wire [7:0] hi_vec;
  wire [7:0] lo_vec;

  esic_prio_pick #(.N(NSRC)) u_pick_hi (
    .req (req_hi),
    .any (hi_any),
    .idx (hi_idx),
    .vec (hi_vec)
  );

  esic_prio_pick #(.N(NSRC)) u_pick_lo (
    .req (req_lo),
    .any (lo_any),
    .idx (lo_idx),
    .vec (lo_vec)
  );

  // high may enter unless a high routine runs; low only when idle
  wire       take_hi  = hi_any & ~in_hi;                  // [R16]
  wire       take_lo  = lo_any & ~in_hi & ~in_lo;         // [R16]
  wire       want     = take_hi | take_lo;
  wire [2:0] win_idx  = take_hi ? hi_idx : lo_idx;
  wire [7:0] win_vec  = take_hi ? hi_vec : lo_vec;
  wire       served   = cpu_irq_ack & cpu_irq_req;
  wire [NSRC-1:0] svc = served ? ({{(NSRC-1){1'b0}}, 1'b1} << cur_idx) : {NSRC{1'b0}};

  // --------------------
  // request and vector towards the core, registered; the source and level
  // are posted with the vector, so service clears what was really vectored
  // --------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_req    <= 1'b0;
      cpu_irq_vector <= `ESIC_RST_BYTE;
      cur_idx        <= 3'h0;
      cur_hi         <= 1'b0;
    end else if (served) begin
      cpu_irq_req    <= 1'b0;         // drop one cycle so flags settle
    end else begin
      cpu_irq_req    <= want;
      cpu_irq_vector <= win_vec;      // [R1] [R2]
      cur_idx        <= win_idx;
      cur_hi         <= take_hi;
    end
  end

  // --------------------
  // in-service tracking; a return ends the higher active level first
  // --------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_hi <= 1'b0;
      in_lo <= 1'b0;
    end else if (served) begin
      if (cur_hi)
        in_hi <= 1'b1;                // [R16]
      else
        in_lo <= 1'b1;
    end else if (cpu_irq_return) begin
      if (in_hi)
        in_hi <= 1'b0;
      else
        in_lo <= 1'b0;
    end
  end

  // --------------------
  // control and flag registers; hardware set wins over software clear
  // --------------------
  wire wr_tc = apb_wr & (paddr == `ESIC_ADDR_TCTRL);
  wire wr_xc = apb_wr & (paddr == `ESIC_ADDR_XCTRL);
  wire wr_t2 = apb_wr & (paddr == `ESIC_ADDR_T2FLAGS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ext_irq_ctrl   <= `ESIC_RST_BYTE;
      ext23_irq_ctrl       <= `ESIC_RST_BYTE;
      irq_enable_reg       <= `ESIC_RST_BYTE;
      irq_priority_reg     <= `ESIC_RST_BYTE;
      tmr2_overflow_flag   <= 1'b0;
      tmr2_transition_flag <= 1'b0;
    end else begin
      if (wr_tc)
        timer_ext_irq_ctrl <= pwdata[7:0];
      // flags: set on event, cleared on vectoring; set beats both clears
      if (tmr0_overflow)
        timer_ext_irq_ctrl[`ESIC_TC_TF0] <= 1'b1;                         // [R11]
      else if (svc[1])
        timer_ext_irq_ctrl[`ESIC_TC_TF0] <= 1'b0;                         // [R11]
      if (tmr1_overflow)
        timer_ext_irq_ctrl[`ESIC_TC_TF1] <= 1'b1;                         // [R12]
      else if (svc[3])
        timer_ext_irq_ctrl[`ESIC_TC_TF1] <= 1'b0;                         // [R12]
      if (fall[0] & it0)
        timer_ext_irq_ctrl[`ESIC_TC_IE0] <= 1'b1;                         // [R14]
      else if (svc[0] | ~it0)
        timer_ext_irq_ctrl[`ESIC_TC_IE0] <= 1'b0;                         // [R14] [R17]
      if (fall[1] & it1)
        timer_ext_irq_ctrl[`ESIC_TC_IE1] <= 1'b1;                         // [R14]
      else if (svc[2] | ~it1)
        timer_ext_irq_ctrl[`ESIC_TC_IE1] <= 1'b0;                         // [R14] [R17]

      if (wr_xc)
        ext23_irq_ctrl <= pwdata[7:0];
      if (fall[2] & it2)
        ext23_irq_ctrl[`ESIC_XC_IE2] <= 1'b1;                             // [R10]
      else if (svc[6] | ~it2)
        ext23_irq_ctrl[`ESIC_XC_IE2] <= 1'b0;                             // [R10] [R17]
      if (fall[3] & it3)
        ext23_irq_ctrl[`ESIC_XC_IE3] <= 1'b1;                             // [R10]
      else if (svc[7] | ~it3)
        ext23_irq_ctrl[`ESIC_XC_IE3] <= 1'b0;                             // [R10] [R17]

      if (apb_wr & (paddr == `ESIC_ADDR_IEN))
        irq_enable_reg   <= pwdata[7:0];
      if (apb_wr & (paddr == `ESIC_ADDR_IPRI))
        irq_priority_reg <= pwdata[7:0];

      // timer 2 flags are never cleared on vectoring, only by software
      if (tmr2_overflow)
        tmr2_overflow_flag <= 1'b1;                                       // [R15]
      else if (wr_t2)
        tmr2_overflow_flag <= pwdata[`ESIC_T2OVF_BIT];
      if (tmr2_transition)
        tmr2_transition_flag <= 1'b1;                                     // [R15]
      else if (wr_t2)
        tmr2_transition_flag <= pwdata[`ESIC_T2EXF_BIT];
    end
  end

  // --------------------
  // sticky event status: a source request rising; read clears, set wins
  // --------------------
  reg  [NSRC-1:0] req_last;           // previous raw requests
  wire            rd_ev = apb_rd & (paddr == `ESIC_ADDR_EVSTAT);
  wire [NSRC-1:0] ev_set = src_req & ~req_last;

  always @* begin
    next_ev_status = rd_ev ? {NSRC{1'b0}} : ev_status;
    next_ev_status = next_ev_status | ev_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_last  <= {NSRC{1'b0}};
      ev_status <= {NSRC{1'b0}};
      ev_mask   <= {NSRC{1'b0}};
    end else begin
      req_last  <= src_req;
      ev_status <= next_ev_status;
      if (apb_wr & (paddr == `ESIC_ADDR_EVMASK))
        ev_mask <= pwdata[NSRC-1:0];
    end
  end

  assign irq = |(ev_status & ev_mask);

  // --------------------
  // read mux, combinational from registers and the level pickers, valid in the access phase
  // --------------------
  always @* begin
    prdata = `ESIC_RST_WORD;
    if (paddr == `ESIC_ADDR_TCTRL)
      prdata[7:0] = timer_ext_irq_ctrl;
    else if (paddr == `ESIC_ADDR_IEN)
      prdata[7:0] = irq_enable_reg;
    else if (paddr == `ESIC_ADDR_IPRI)
      prdata[5:0] = irq_priority_reg[5:0];   // top two bits unused, read zero
    else if (paddr == `ESIC_ADDR_XCTRL)
      prdata[7:0] = ext23_irq_ctrl;
    else if (paddr == `ESIC_ADDR_T2FLAGS)
      prdata[7:6] = {tmr2_overflow_flag, tmr2_transition_flag};
    else if (paddr == `ESIC_ADDR_ACK)
      prdata[11:0] = {in_hi, in_lo, cpu_irq_req, win_idx, 6'h00};
    else if (paddr == `ESIC_ADDR_EVSTAT)
      prdata[NSRC-1:0] = ev_status;
    else if (paddr == `ESIC_ADDR_EVMASK)
      prdata[NSRC-1:0] = ev_mask;
    else
      prdata = `ESIC_ERR_WORD;
  end
endmodule

/* File: rtl/esic_defines.vh */
// constants for the eight source interrupt controller
`ifndef ESIC_DEFINES_VH
`define ESIC_DEFINES_VH

// --------------------
// register byte addresses (apb, 32-bit words)
// --------------------
`define ESIC_ADDR_TCTRL    8'h88
`define ESIC_ADDR_IEN      8'ha8
`define ESIC_ADDR_IPRI     8'hb8
`define ESIC_ADDR_XCTRL    8'hc0
`define ESIC_ADDR_T2FLAGS  8'hc8
`define ESIC_ADDR_ACK      8'hd0
`define ESIC_ADDR_EVSTAT   8'hd4
`define ESIC_ADDR_EVMASK   8'hd8

// --------------------
// field positions
// --------------------
`define ESIC_GLOBAL_BIT    7
`define ESIC_T2OVF_BIT     7
`define ESIC_T2EXF_BIT     6
`define ESIC_TC_TF1        7
`define ESIC_TC_TF0        5
`define ESIC_TC_IE1        3
`define ESIC_TC_IT1        2
`define ESIC_TC_IE0        1
`define ESIC_TC_IT0        0
`define ESIC_XC_PX3        7
`define ESIC_XC_EX3        6
`define ESIC_XC_IE3        5
`define ESIC_XC_IT3        4
`define ESIC_XC_PX2        3
`define ESIC_XC_EX2        2
`define ESIC_XC_IE2        1
`define ESIC_XC_IT2        0

// --------------------
// reset values
// --------------------
`define ESIC_RST_BYTE      8'h00
`define ESIC_RST_WORD      32'h0000_0000
`define ESIC_ERR_WORD      32'h0000_0000

// --------------------
// vector addresses, one per source
// --------------------
`define ESIC_VEC_EXT0      8'h03
`define ESIC_VEC_TMR0      8'h0b
`define ESIC_VEC_EXT1      8'h13
`define ESIC_VEC_TMR1      8'h1b
`define ESIC_VEC_SER       8'h23
`define ESIC_VEC_TMR2      8'h2b
`define ESIC_VEC_EXT2      8'h33
`define ESIC_VEC_EXT3      8'h3b

`endif

/* File: rtl/esic_prio_pick.v */
// fixed-order pick of the lowest numbered request in an eight bit set
`timescale 1ns/1ns
`include "esic_defines.vh"

module esic_prio_pick #(
  parameter N = 8                   // number of sources
) (
  req,
  any,
  idx,
  vec
);
  input  wire [N-1:0] req;          // requests at one level
  output reg          any;          // some request present
  output reg  [2:0]   idx;          // winning source number
  output reg  [7:0]   vec;          // vector of the winner

  integer i;

  // --------------------
  // polling order: bit 0 first, scanning down so the lowest index wins
  // --------------------
  always @* begin
    any = 1'b0;
    idx = 3'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;                 // [R3]
        idx = i[2:0];
      end
    end
    case (idx)                      // [R1] [R2]
      3'h0: vec = `ESIC_VEC_EXT0;
      3'h1: vec = `ESIC_VEC_TMR0;
      3'h2: vec = `ESIC_VEC_EXT1;
      3'h3: vec = `ESIC_VEC_TMR1;
      3'h4: vec = `ESIC_VEC_SER;
      3'h5: vec = `ESIC_VEC_TMR2;
      3'h6: vec = `ESIC_VEC_EXT2;
      default: vec = `ESIC_VEC_EXT3;
    endcase
  end
endmodule

/* File: verif/esic_chk_sva.sv */
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
`include "esic_defines.vh"
module esic_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        cpu_irq_req,
  input wire [7:0]  cpu_irq_vector,
  input wire        cpu_irq_ack,
  input wire        irq
);
  // --------------------
  // shadow copies of software written bytes
  // --------------------
  reg  [7:0] ien;                             // enable byte
  reg  [7:0] xc;                              // extra control, only enable bits trusted
  reg  [7:0] ipr;                             // priority byte
  reg  [7:0] evm;                             // event mask
  reg  [7:0] xv;                              // vector of the lone enabled source
  integer    k;                               // source index
  wire       acc = psel && penable;           // access edge, pready is always high
  wire [7:0] en8 = {xc[6], xc[2], ien[5:0]};  // enables in polling order
  wire       map = paddr inside {`ESIC_ADDR_TCTRL, `ESIC_ADDR_IEN, `ESIC_ADDR_IPRI, `ESIC_ADDR_XCTRL,
                   `ESIC_ADDR_T2FLAGS, `ESIC_ADDR_ACK, `ESIC_ADDR_EVSTAT, `ESIC_ADDR_EVMASK};
  // writes land at the same edge as in the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien <= 8'h00;
      xc <= 8'h00;
      ipr <= 8'h00;
      evm <= 8'h00;
    end else if (acc && pwrite) begin
      if (paddr == `ESIC_ADDR_IEN) ien <= pwdata[7:0];
      if (paddr == `ESIC_ADDR_XCTRL) xc <= pwdata[7:0];
      if (paddr == `ESIC_ADDR_IPRI) ipr <= pwdata[7:0];
      if (paddr == `ESIC_ADDR_EVMASK) evm <= pwdata[7:0];
    end
  end
  // vectors step by eight from the first one
  always @* begin
    xv = 8'h00;
    for (k = 0; k < 8; k = k + 1)
      if (en8[k]) xv = 8'h03 + {k[4:0], 3'b000};
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------
  // assertions
  // --------------------
  chk_single_vec: assert property (
    ien[7] && $onehot(en8) && $stable(en8) && cpu_irq_req |-> cpu_irq_vector == xv)
    else $error("vector is not that of the only enabled source");
  chk_global_off: assert property (
    !ien[7] && !$past(ien[7]) |-> !cpu_irq_req) else $error("request while globally disabled");
  chk_ack_drop: assert property (
    cpu_irq_ack && cpu_irq_req |=> !cpu_irq_req) else $error("request stays up after ack");
  chk_prio_read: assert property (
    acc && !pwrite && paddr == `ESIC_ADDR_IPRI |-> prdata == {26'h0, ipr[5:0]})
    else $error("priority readback wrong");
  chk_ien_read: assert property (
    acc && !pwrite && paddr == `ESIC_ADDR_IEN |-> prdata[7] == ien[7] && prdata[5:0] == ien[5:0])
    else $error("enable readback wrong");
  chk_unmap_err: assert property (
    acc && !map |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  chk_map_ok: assert property (
    acc && !pwrite && map |-> !pslverr) else $error("mapped read refused");
  chk_irq_mask: assert property (
    evm == 8'h00 |-> !irq) else $error("irq high with all events masked");
endmodule
bind esic_irq_ctrl esic_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector), .cpu_irq_ack(cpu_irq_ack), .irq(irq));

/* File: verif/esic_cpu_model.sv */
// core model that takes vectors and returns from routines
`timescale 1ns/1ns
module esic_cpu_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       cpu_irq_req,
  input  wire [7:0] cpu_irq_vector,
  input  wire       accept,         // core allows vectoring
  input  wire [3:0] lag,            // cycles of request seen before ack
  input  wire       do_ret,         // finish the innermost routine
  output reg        cpu_irq_ack,
  output reg        cpu_irq_return,
  output reg        taken,          // a vector was taken one edge ago
  output reg  [7:0] taken_vec
);
  reg [3:0] cnt;                    // wait before acking, models a slow core
  // ack rises after lag edges with the request high and is always dropped at the next edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_ack <= 1'b0;
      cpu_irq_return <= 1'b0;
      taken <= 1'b0;
      taken_vec <= 8'h00;
      cnt <= 4'h0;
    end else begin
      taken <= cpu_irq_ack && cpu_irq_req;
      cpu_irq_return <= do_ret;
      if (cpu_irq_ack && cpu_irq_req) taken_vec <= cpu_irq_vector;
      if (cpu_irq_ack || !cpu_irq_req || !accept) begin
        cpu_irq_ack <= 1'b0;
        cnt <= 4'h0;
      end else if (cnt == lag) cpu_irq_ack <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end
endmodule

/* File: verif/eight_source_interrupt_controller_tb.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`include "esic_defines.vh"
module eight_source_interrupt_controller_tb;
  reg          pclk, presetn, psel, penable, pwrite;  // clock, reset, apb controls
  reg  [7:0]   paddr;
  reg  [31:0]  pwdata;
  reg  [3:0]   pin;                                   // external pins 3..0, active low
  reg          t0, t1, t2o, t2x, ser;                 // timer pulses, serial level
  reg          accept, do_ret;                        // core model controls
  reg  [3:0]   lag;                                   // core ack delay
  wire [31:0]  prdata;
  wire         pready, pslverr, req, ack, ret, irq, taken;
  wire [7:0]   vec, tvec;
  logic [31:0] rd_q[$];                               // expected read data
  logic [7:0]  vec_q[$];                              // expected vectors
  integer      n_fail, checked, i, j;
  reg  [31:0]  r, xcv;
  reg  [47:0]  vl;                                    // polling order vectors
  esic_irq_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext0_irq_pin(pin[0]), .ext1_irq_pin(pin[1]), .ext2_irq_pin(pin[2]), .ext3_irq_pin(pin[3]),
    .tmr0_overflow(t0), .tmr1_overflow(t1), .tmr2_overflow(t2o), .tmr2_transition(t2x),
    .serial_req(ser), .cpu_irq_req(req), .cpu_irq_vector(vec), .cpu_irq_ack(ack),
    .cpu_irq_return(ret), .irq(irq));
  esic_cpu_model mdl_u (.pclk(pclk), .presetn(presetn), .cpu_irq_req(req), .cpu_irq_vector(vec),
    .accept(accept), .lag(lag), .do_ret(do_ret), .cpu_irq_ack(ack), .cpu_irq_return(ret),
    .taken(taken), .taken_vec(tvec));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // --------------------
  // shared tasks
  // --------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task timeout;
    n_fail = n_fail + 1;
    give_verdict;
  endtask
  // one apb transfer, idle edge after so tasks chain safely
  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n = n + 1;
      if (n > 20) timeout;
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    rd_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  // pulse sources for one cycle, serial raised and held; mask bit per source in polling order
  task fire(input [7:0] m);
    pin <= ~{m[7], m[6], m[2], m[0]};
    t0 <= m[1];
    t1 <= m[3];
    t2o <= m[5];
    t2x <= m[5];
    if (m[4]) ser <= 1'b1;
    @(posedge pclk);
    pin <= 4'hf;
    {t0, t1, t2o, t2x} <= 4'h0;
  endtask
  // note the vector and wait for the core to take one
  task take(input [7:0] v);
    integer n;
    n = 0;
    vec_q.push_back(v);
    lag <= 4'($urandom % 5);
    @(posedge pclk);
    while (taken !== 1'b1) begin
      n = n + 1;
      if (n > 80) timeout;
      @(posedge pclk);
    end
  endtask
  task leave;
    do_ret <= 1'b1;
    @(posedge pclk);
    do_ret <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task none;
    repeat (12) begin
      @(posedge pclk);
      check({31'h0, taken}, 32'h0);
    end
  endtask
  // results are compared as they show up at the ports
  always @(posedge pclk) begin
    if (presetn && psel && penable && !pwrite) check(prdata, rd_q.pop_front());
    if (taken) check({24'h0, tvec}, {24'h0, vec_q.pop_front()});
  end
  // --------------------
  // main sequence
  // --------------------
  initial begin
    {psel, penable, pwrite, t0, t1, t2o, t2x, ser, accept, do_ret, presetn} = 11'h0;
    {paddr, pwdata, pin, lag} = 48'h0000_0000_00f0;
    n_fail = 0;
    checked = 0;
    vl = 48'h03_0b_13_1b_33_3b;
    r = $urandom(40);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ESIC_ADDR_TCTRL, 32'h0);
    rd(`ESIC_ADDR_IEN, 32'h0);
    rd(`ESIC_ADDR_XCTRL, 32'h0);
    r = $urandom;
    wr(`ESIC_ADDR_IPRI, r);
    rd(`ESIC_ADDR_IPRI, r & 32'h3f);
    rd(8'he0, 32'h0);
    $display("test 1 done");
    wr(`ESIC_ADDR_IPRI, 32'h0);
    wr(`ESIC_ADDR_TCTRL, 32'h05);
    accept <= 1'b1;
    // each source alone, pins in edge mode
    for (i = 0; i < 8; i = i + 1) begin
      xcv = (i == 6) ? 32'h15 : (i == 7) ? 32'h51 : 32'h11;
      wr(`ESIC_ADDR_IEN, (i < 6) ? (32'h80 | (32'h1 << i)) : 32'h80);
      wr(`ESIC_ADDR_XCTRL, xcv);
      fire(8'h01 << i);
      take(8'h03 + 8'(8 * i));
      ser <= 1'b0;
      if (i == 5) rd(`ESIC_ADDR_T2FLAGS, 32'hc0);
      if (i == 5) wr(`ESIC_ADDR_T2FLAGS, 32'h0);
      rd(`ESIC_ADDR_TCTRL, 32'h05);
      rd(`ESIC_ADDR_XCTRL, xcv);
      leave;
    end
    $display("test 2 done");
    wr(`ESIC_ADDR_IEN, 32'h3f);
    fire(8'h02);
    none;
    wr(`ESIC_ADDR_IEN, 32'h82);
    take(8'h0b);
    leave;
    $display("test 3 done");
    accept <= 1'b0;
    wr(`ESIC_ADDR_IEN, 32'h8f);
    wr(`ESIC_ADDR_XCTRL, 32'h55);
    fire(8'hcf);
    accept <= 1'b1;
    for (j = 0; j < 6; j = j + 1) begin
      take(vl[8 * (5 - j) +: 8]);
      leave;
    end
    $display("test 4 done");
    accept <= 1'b0;
    wr(`ESIC_ADDR_IEN, 32'h82);
    wr(`ESIC_ADDR_XCTRL, 32'hd1);
    fire(8'h82);
    accept <= 1'b1;
    take(8'h3b);
    none;
    rd(`ESIC_ADDR_ACK, 32'h840);
    leave;
    take(8'h0b);
    fire(8'h80);
    take(8'h3b);
    leave;
    leave;
    accept <= 1'b0;
    wr(`ESIC_ADDR_XCTRL, 32'h11);
    wr(`ESIC_ADDR_IPRI, 32'h08);
    wr(`ESIC_ADDR_IEN, 32'h89);
    fire(8'h09);
    accept <= 1'b1;
    take(8'h1b);
    leave;
    take(8'h03);
    leave;
    $display("test 5 done");
    wr(`ESIC_ADDR_IPRI, 32'h0);
    wr(`ESIC_ADDR_TCTRL, 32'h0);
    wr(`ESIC_ADDR_IEN, 32'h81);
    pin[0] <= 1'b0;
    take(8'h03);
    rd(`ESIC_ADDR_TCTRL, 32'h0);
    pin[0] <= 1'b1;
    leave;
    none;
    $display("test 6 done");
    accept <= 1'b0;
    rd(`ESIC_ADDR_EVSTAT, 32'hff);
    wr(`ESIC_ADDR_EVMASK, 32'h02);
    wr(`ESIC_ADDR_IEN, 32'h82);
    fire(8'h02);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rd(`ESIC_ADDR_EVSTAT, 32'h02);
    check({31'h0, irq}, 32'h0);
    wr(`ESIC_ADDR_EVMASK, 32'h0);
    accept <= 1'b1;
    take(8'h0b);
    leave;
    $display("test 7 done");
    give_verdict;
  end
endmodule
